// *** hdl/lpmc_pkg.sv ***
package lpmc_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 4;
  localparam int NUM_IRQ = 8;
  localparam int NUM_AIRQ = 4;
  localparam int NUM_WAKE = 2;
  localparam int NUM_PIN = 9;
  localparam int GP_AW = 2;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLKCFG = 8'h04;
  localparam logic [7:0] OFF_IRQEN = 8'h08;
  localparam logic [7:0] OFF_SWITCH = 8'h0c;
  localparam logic [7:0] OFF_BODLVL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_ORIGIN = 8'h18;
  localparam logic [3:0] GP_PAGE = 4'h2;
  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_IOHOLD = 8;
  localparam int CTRL_LPREG = 9;
  localparam int CLK_RUNLP = 8;
  localparam int SW_WAKE = 2;
  localparam int SW_GATE = 3;
  localparam int SW_ACT = 4;
  localparam int SW_MSEL = 6;
  localparam int ORG_POR = 0;
  localparam int ORG_BKUP = 2;
  localparam int ORG_CAUSE = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0307;
  localparam logic [31:0] CLKCFG_MASK = 32'h0000_0f0f;
  localparam logic [31:0] IRQEN_MASK = 32'h0000_00ff;
  localparam logic [31:0] SWITCH_MASK = 32'h0000_007f;
  localparam logic [31:0] BODLVL_MASK = 32'h0000_003f;
  localparam logic [31:0] CTRL_RST = 32'h0000_0200;
  localparam logic [31:0] CLKCFG_RST = 32'h0000_0000;
  localparam logic [31:0] IRQEN_RST = 32'h0000_0000;
  localparam logic [31:0] SWITCH_RST = 32'h0000_0000;
  localparam logic [31:0] BODLVL_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_IDLE = 3'h2;
  localparam logic [2:0] SEL_STANDBY = 3'h4;
  localparam logic [2:0] SEL_BACKUP = 3'h5;
  localparam logic [1:0] SW_NONE = 2'h0;
  localparam logic [1:0] SW_AUTO = 2'h1;
  localparam logic [1:0] SW_FORCED = 2'h2;
  localparam logic [1:0] SW_BROWNOUT = 2'h3;
  localparam logic [1:0] ACT_BACKUP = 2'h3;
  localparam logic MSEL_MAIN = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    ST_ACTIVE = 5'h01,
    ST_IDLE = 5'h02,
    ST_STANDBY = 5'h04,
    ST_BACKUP = 5'h08,
    ST_WAKE = 5'h10
  } lpmc_state_t;
endpackage

// *** hdl/lpmc_gp_if.sv ***
`timescale 1ns/1ps
interface lpmc_gp_if;
  logic we;
  logic [1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [1:0] raddr;
  logic [31:0] rdata;
  modport ctrl (output we, waddr, wdata, wstrb, raddr, input rdata);
  modport mem (input we, waddr, wdata, wstrb, raddr, output rdata);
endinterface

// *** hdl/lpmc_gpmem.sv ***
`timescale 1ns/1ps
module lpmc_gpmem
  import lpmc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Access port
  lpmc_gp_if.mem gp
);
  logic [31:0] mem_r [2**GP_AW];

  // ----------------------------------------------------------------
  // Backup-domain words: cleared only by a full reset
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2**GP_AW; i++) begin
        mem_r[i] <= 32'h0000_0000;
      end
    end else if (gp.we) begin
      for (int b = 0; b < 4; b++) begin
        if (gp.wstrb[b]) begin
          mem_r[gp.waddr][8*b +: 8] <= gp.wdata[8*b +: 8];
        end
      end
    end
  end

  // Registered read, one cycle behind raddr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gp.rdata <= 32'h0000_0000;
    end else begin
      gp.rdata <= mem_r[gp.raddr];
    end
  end
endmodule // lpmc_gpmem

// *** hdl/lpmc_top.sv ***
// Notes on behaviour
// - WFI with Idle code enters Idle and stops the CPU clock.
// - Idle: bus clocks off unless a peripheral requests them.
// - Idle: generic clocks run, or only on request when on-demand.
// - Any enabled interrupt ends Idle.
// - WFI with Standby code enters Standby.
// - Standby: every clock off except the always-on slow oscillator; the code keeps run-in-Standby generic clocks on, on-demand ones only on request.
// - Keep-running peripherals work in Standby; on-demand starts on request.
// - Any asynchronous interrupt ends Standby.
// - Standby moves the core supply to the low-power regulator by default.
// - WFI with Backup code: only backup domain stays powered.
// - Backup wake restarts like reset; backup registers are kept.
// - Hold-on-wake bit decides whether I/O keeps state after Backup.
// - Reset-origin register names the cause, Backup wake distinct.
// - General-purpose words survive Backup to record wake cause.
// - Only wake pins, real-time counter or supply switch end Backup.
// - After reset, switch setting is no-action and supply is main.
// - Forced setting feeds the backup domain from battery.
// - Automatic: drop goes to battery and Backup, returns when restored; the code does not switch to battery on a drop during Backup.
// - Wake-on-restore decides whether restore ends Backup.
// - Brown-out setting enters Backup if action and monitor allow.
// - Threshold is main level in Backup, battery level otherwise.
// - Gate set, not automatic: good-pin rise returns to main supply; the code keeps the forced setting on battery.
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module lpmc_top
  import lpmc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU and peripheral requests, same clock
  input wire logic wfi_exec,
  input wire logic [NUM_IRQ-1:0] irq_line,
  input wire logic [NUM_SRC-1:0] bus_clk_req,
  input wire logic [NUM_SRC-1:0] gclk_req,
  input wire logic rtc_irq,
  // Asynchronous pins and supply monitors
  input wire logic [NUM_AIRQ-1:0] async_irq,
  input wire logic [NUM_WAKE-1:0] ext_wake_pin,
  input wire logic main_supply_low,
  input wire logic main_supply_good_pin,
  input wire logic supply_brownout_trip,
  // Clock and power controls
  output logic cpu_clk_en,
  output logic bus_clk_en,
  output logic [NUM_SRC-1:0] generic_peripheral_clock_en,
  output logic always_on_slow_osc_en,
  output logic low_power_regulator_sel,
  output logic main_power_en,
  output logic backup_domain_on_battery,
  output logic io_hold,
  output logic restart_req,
  output logic [5:0] brownout_threshold,
  output logic brownout_ref_main
);
  lpmc_state_t state_r;
  logic [31:0] ctrl_r, clkcfg_r, irqen_r, switch_r, bodlvl_r, origin_r;
  logic [NUM_PIN-1:0] pin_s;
  logic [NUM_AIRQ-1:0] airq_s;
  logic [NUM_WAKE-1:0] wake_s;
  logic low_s, good_s, bod_s, good_d_r;
  logic [2:0] cause_r;
  logic [NUM_SRC-1:0] gclk_nxt;
  logic wr_take, wr_fire, ar_take, ar_fire, rd_pend_r, rd_gp_r;
  logic [7:0] rd_addr_r;
  logic [31:0] rd_mux;
  logic [1:0] sset;
  logic drop, restore, good_rise, back_main, wake_evt;
  lpmc_gp_if gp();

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PIN; gi++) begin : g_sync
      logic s1_r, s2_r;
      // First stage feeds only the second
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= (gi < NUM_AIRQ) ? async_irq[gi % NUM_AIRQ] :
                  (gi < NUM_AIRQ + NUM_WAKE) ?
                  ext_wake_pin[gi % NUM_WAKE] :
                  (gi == NUM_PIN - 3) ? main_supply_low :
                  (gi == NUM_PIN - 2) ? main_supply_good_pin :
                  supply_brownout_trip;
          s2_r <= s1_r;
        end
      end
      assign pin_s[gi] = s2_r;
    end
  endgenerate
  assign airq_s = pin_s[NUM_AIRQ-1:0];
  assign wake_s = pin_s[NUM_AIRQ +: NUM_WAKE];
  assign low_s = pin_s[NUM_PIN-3];
  assign good_s = pin_s[NUM_PIN-2];
  assign bod_s = pin_s[NUM_PIN-1];

  // Delayed good-pin copy for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      good_d_r <= 1'b0;
    end else begin
      good_d_r <= good_s;
    end
  end

  // ----------------------------------------------------------------
  // Supply switch events
  // ----------------------------------------------------------------
  assign sset = switch_r[1:0];
  assign good_rise = good_s & ~good_d_r;
  assign drop = state_r != ST_BACKUP &&
                ((sset == SW_AUTO && low_s) ||
                 (sset == SW_BROWNOUT && bod_s &&
                  switch_r[SW_ACT +: 2] == ACT_BACKUP &&
                  switch_r[SW_MSEL] == MSEL_MAIN));
  assign restore = sset == SW_AUTO && !low_s;
  assign back_main = restore || (sset != SW_AUTO &&
                     switch_r[SW_GATE] && good_rise);
  // Wake on restore only when the supply was actually on battery
  assign wake_evt = |wake_s || rtc_irq ||
                    (switch_r[SW_WAKE] && back_main &&
                     backup_domain_on_battery);

  // Battery switch; no-action setting holds the present supply except on a gated good-pin rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      backup_domain_on_battery <= 1'b0;
    end else if (sset == SW_FORCED) begin
      backup_domain_on_battery <= 1'b1;
    end else if (drop) begin
      backup_domain_on_battery <= 1'b1;
    end else if (back_main) begin
      backup_domain_on_battery <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_ACTIVE;
      cause_r <= 3'h0;
    end else begin
      case (state_r)
        ST_ACTIVE: begin
          if (drop) begin
            state_r <= ST_BACKUP;
          end else if (wfi_exec) begin
            case (ctrl_r[2:0])
              SEL_IDLE: state_r <= ST_IDLE;
              SEL_STANDBY: state_r <= ST_STANDBY;
              SEL_BACKUP: state_r <= ST_BACKUP;
              default: state_r <= ST_ACTIVE;
            endcase
          end
        end
        ST_IDLE: begin
          if (drop) begin
            state_r <= ST_BACKUP;
          end else if (|(irq_line & irqen_r[NUM_IRQ-1:0])) begin
            state_r <= ST_ACTIVE;
          end
        end
        ST_STANDBY: begin
          if (drop) begin
            state_r <= ST_BACKUP;
          end else if (|airq_s) begin
            state_r <= ST_ACTIVE;
          end
        end
        ST_BACKUP: begin
          // Interrupt lines and async pins are deliberately ignored
          if (wake_evt) begin
            state_r <= ST_WAKE;
            cause_r <= {back_main, rtc_irq, |wake_s};
          end
        end
        ST_WAKE: state_r <= ST_ACTIVE;
        default: state_r <= ST_ACTIVE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock and power outputs, one cycle behind the state
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_gclk
      logic ok;
      assign ok = ~clkcfg_r[gi] | gclk_req[gi];
      assign gclk_nxt[gi] = state_r == ST_ACTIVE ||
                            (state_r == ST_IDLE && ok) ||
                            (state_r == ST_STANDBY && ok &&
                             clkcfg_r[CLK_RUNLP + gi]);
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en <= 1'b1;
      bus_clk_en <= 1'b1;
      generic_peripheral_clock_en <= '1;
      always_on_slow_osc_en <= 1'b1;
      low_power_regulator_sel <= 1'b0;
      main_power_en <= 1'b1;
      restart_req <= 1'b0;
    end else begin
      cpu_clk_en <= state_r == ST_ACTIVE;
      bus_clk_en <= state_r == ST_ACTIVE ||
                    (state_r == ST_IDLE && |bus_clk_req);
      generic_peripheral_clock_en <= gclk_nxt;
      always_on_slow_osc_en <= 1'b1;
      low_power_regulator_sel <= state_r == ST_STANDBY &&
                                 ctrl_r[CTRL_LPREG];
      main_power_en <= state_r != ST_BACKUP;
      restart_req <= state_r == ST_WAKE;
    end
  end

  // I/O hold: set in Backup, released by clearing the hold bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_hold <= 1'b0;
    end else begin
      io_hold <= state_r == ST_BACKUP ||
                 (io_hold && ctrl_r[CTRL_IOHOLD]);
    end
  end

  // Threshold meaning follows the supply being watched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brownout_threshold <= 6'h00;
      brownout_ref_main <= 1'b0;
    end else begin
      brownout_threshold <= bodlvl_r[5:0];
      brownout_ref_main <= state_r == ST_BACKUP;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  function automatic logic lpmc_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && (a <= OFF_ORIGIN || a[7:4] == GP_PAGE);
  endfunction

  function automatic logic [31:0] lpmc_strb(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Both halves of a write are taken together, one write at a time
  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
                   ~s_axi_bvalid;
  assign wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wready &
                   s_axi_wvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_take;
      s_axi_wready <= wr_take;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= lpmc_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; a Backup wake restores the core-domain ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      clkcfg_r <= CLKCFG_RST;
      irqen_r <= IRQEN_RST;
      switch_r <= SWITCH_RST;
      bodlvl_r <= BODLVL_RST;
    end else if (state_r == ST_WAKE) begin
      ctrl_r <= CTRL_RST & ~(32'h1 << CTRL_IOHOLD) |
                ctrl_r & (32'h1 << CTRL_IOHOLD);
      clkcfg_r <= CLKCFG_RST;
      irqen_r <= IRQEN_RST;
    end else if (wr_fire) begin
      case (s_axi_awaddr)
        OFF_CTRL: ctrl_r <= lpmc_strb(ctrl_r, s_axi_wdata,
                                      s_axi_wstrb) & CTRL_MASK;
        OFF_CLKCFG: clkcfg_r <= lpmc_strb(clkcfg_r, s_axi_wdata,
                                          s_axi_wstrb) & CLKCFG_MASK;
        OFF_IRQEN: irqen_r <= lpmc_strb(irqen_r, s_axi_wdata,
                                        s_axi_wstrb) & IRQEN_MASK;
        OFF_SWITCH: switch_r <= lpmc_strb(switch_r, s_axi_wdata,
                                          s_axi_wstrb) & SWITCH_MASK;
        OFF_BODLVL: bodlvl_r <= lpmc_strb(bodlvl_r, s_axi_wdata,
                                          s_axi_wstrb) & BODLVL_MASK;
        default: ;
      endcase
    end
  end

  // Reset origin: power-on, or Backup wake with its cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      origin_r <= 32'h1 << ORG_POR;
    end else if (state_r == ST_WAKE) begin
      origin_r <= (32'h1 << ORG_BKUP) |
                  ({29'h0, cause_r} << ORG_CAUSE);
    end
  end

  // General-purpose words sit in their own memory
  assign gp.we = wr_fire && s_axi_awaddr[7:4] == GP_PAGE;
  assign gp.waddr = s_axi_awaddr[3:2];
  assign gp.wdata = s_axi_wdata;
  assign gp.wstrb = s_axi_wstrb;
  assign gp.raddr = s_axi_araddr[3:2];
  lpmc_gpmem u_gpmem (
    .aclk(aclk),
    .aresetn(aresetn),
    .gp(gp.mem)
  );

  // Read path: extra stage so the memory word is ready
  assign ar_take = s_axi_arvalid & ~s_axi_arready & ~rd_pend_r &
                   ~s_axi_rvalid;
  assign ar_fire = s_axi_arready & s_axi_arvalid;
  always_comb begin
    case (rd_addr_r)
      OFF_CTRL: rd_mux = ctrl_r;
      OFF_CLKCFG: rd_mux = clkcfg_r;
      OFF_IRQEN: rd_mux = irqen_r;
      OFF_SWITCH: rd_mux = switch_r;
      OFF_BODLVL: rd_mux = bodlvl_r;
      OFF_STATUS: rd_mux = {22'h0, io_hold, backup_domain_on_battery,
                            3'h0, state_r};
      OFF_ORIGIN: rd_mux = origin_r;
      default: rd_mux = rd_gp_r ? gp.rdata : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_gp_r <= 1'b0;
      rd_addr_r <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ar_take;
      rd_pend_r <= ar_fire;
      if (ar_fire) begin
        rd_addr_r <= s_axi_araddr;
        rd_gp_r <= s_axi_araddr[7:4] == GP_PAGE;
      end
      if (rd_pend_r) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= lpmc_mapped(rd_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  idle_entry_a: assert property (state_r == ST_ACTIVE && !drop &&
    wfi_exec && ctrl_r[2:0] == SEL_IDLE |=> state_r == ST_IDLE ##1
    !cpu_clk_en) else $error("idle not entered");
  bus_gate_a: assert property (state_r == ST_IDLE &&
    !(|bus_clk_req) |=> !bus_clk_en) else $error("bus clock on");
  gclk_demand_a: assert property (state_r == ST_IDLE &&
    clkcfg_r[2] && !gclk_req[2] |=> !generic_peripheral_clock_en[2])
    else $error("on-demand clock ran");
  idle_exit_a: assert property (state_r == ST_IDLE && !drop &&
    |(irq_line & irqen_r[NUM_IRQ-1:0]) |=> state_r == ST_ACTIVE)
    else $error("idle not left");
  stby_entry_a: assert property (state_r == ST_ACTIVE && !drop &&
    wfi_exec && ctrl_r[2:0] == SEL_STANDBY |=> state_r == ST_STANDBY)
    else $error("standby not entered");
  stby_clk_a: assert property (state_r == ST_STANDBY |=>
    !bus_clk_en && !cpu_clk_en && always_on_slow_osc_en)
    else $error("clock on in standby");
  stby_exit_a: assert property (state_r == ST_STANDBY && !drop &&
    |airq_s |=> state_r == ST_ACTIVE) else $error("standby not left");
  lpreg_a: assert property (state_r == ST_STANDBY &&
    ctrl_r[CTRL_LPREG] |=> low_power_regulator_sel)
    else $error("regulator not switched");
  bkup_power_a: assert property (state_r == ST_BACKUP |=>
    !main_power_en && io_hold) else $error("core powered in backup");
  wake_restart_a: assert property (state_r == ST_BACKUP &&
    wake_evt |=> state_r == ST_WAKE ##1 restart_req &&
    origin_r[ORG_BKUP]) else $error("backup wake wrong");
  bkup_hold_a: assert property (state_r == ST_BACKUP &&
    !wake_evt |=> state_r == ST_BACKUP) else $error("stray wake");
  forced_a: assert property (sset == SW_FORCED |=>
    backup_domain_on_battery) else $error("forced not battery");
  auto_drop_a: assert property (state_r == ST_ACTIVE &&
    sset == SW_AUTO && low_s |=> state_r == ST_BACKUP &&
    backup_domain_on_battery) else $error("auto drop missed");
  good_pin_a: assert property (sset[1] == sset[0] && !drop &&
    switch_r[SW_GATE] && good_rise |=> !backup_domain_on_battery)
    else $error("good pin ignored");

  idle_trip_c: cover property (state_r == ST_IDLE ##1
    state_r == ST_ACTIVE);
  stby_trip_c: cover property (state_r == ST_STANDBY ##1
    state_r == ST_ACTIVE);
  bkup_wake_c: cover property (state_r == ST_WAKE);
  auto_sw_c: cover property (sset == SW_AUTO && drop);
endmodule // lpmc_top

// *** verif/lpmc_supply_model.sv ***
`timescale 1ns/1ps
module lpmc_supply_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Supply loss command from the bench
  input wire logic drop,
  // Monitor outputs
  output logic main_supply_low,
  output logic main_supply_good_pin
);
  logic [2:0] ok_cnt_r;
  // Good pin rises only once the supply has been steady a while
  always_ff @(posedge aclk) begin
    if (!aresetn || drop) begin
      ok_cnt_r <= 3'h0;
      main_supply_good_pin <= 1'b0;
    end else if (ok_cnt_r != 3'h7) begin
      ok_cnt_r <= ok_cnt_r + 3'h1;
    end else begin
      main_supply_good_pin <= 1'b1;
    end
  end
  // Low flag follows the supply directly
  assign main_supply_low = drop;
endmodule // lpmc_supply_model

// *** verif/low_power_mode_controller_tb.sv ***
`timescale 1ns/1ps
module low_power_mode_controller_tb;
  import lpmc_pkg::*;
  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] clk;
    logic [3:0] br;
    logic [3:0] gr;
    logic [3:0] eg;
    logic [7:0] irq;
    logic [3:0] air;
    logic [1:0] wk;
    logic [3:0] exp_cbrm;
  } lpmc_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, wfi_exec = 1'b0, rtc_irq = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, drop = 1'b0;
  logic supply_brownout_trip = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, irq_line = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [3:0] s_axi_wstrb = 4'hf, bus_clk_req = 4'h0, gclk_req = 4'h0;
  logic [3:0] async_irq = 4'h0, generic_peripheral_clock_en;
  logic [1:0] ext_wake_pin = 2'h0, s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_clk_en, bus_clk_en, always_on_slow_osc_en;
  logic low_power_regulator_sel, main_power_en, backup_domain_on_battery;
  logic io_hold, restart_req, brownout_ref_main, seen;
  logic main_supply_low, main_supply_good_pin;
  logic [31:0] s_axi_rdata;
  logic [5:0] brownout_threshold;
  int err_count = 0, comparisons = 0, cyc = 0;
  lpmc_row_t rows [4], r;
  lpmc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wfi_exec, .irq_line, .bus_clk_req, .gclk_req, .rtc_irq, .async_irq,
    .ext_wake_pin, .main_supply_low, .main_supply_good_pin,
    .supply_brownout_trip, .cpu_clk_en, .bus_clk_en,
    .generic_peripheral_clock_en, .always_on_slow_osc_en,
    .low_power_regulator_sel, .main_power_en, .backup_domain_on_battery,
    .io_hold, .restart_req, .brownout_threshold, .brownout_ref_main);
  lpmc_supply_model u_far (.aclk, .aresetn, .drop, .main_supply_low,
    .main_supply_good_pin);
  // ----------------------------------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------------------------------
  initial forever #2.5 aclk = ~aclk;
  // Far beyond the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge aclk);
  endtask
  // Address and data offered together, each held until taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tick(2);
  endtask
  task automatic rdr(logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Wake latency is open, so watch a fixed generous span
  task automatic wake_wait;
    seen = 1'b0;
    repeat (40) begin
      @(posedge aclk);
      if (restart_req === 1'b1) seen = 1'b1;
    end
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{32'h2, 32'h0, 4'h0, 4'h0, 4'hf, 8'h01, 4'h0, 2'h0, 4'h1};
    rows[1] = '{32'h2, 32'hf, 4'h1, 4'h3, 4'h3, 8'h80, 4'h0, 2'h0, 4'h5};
    rows[2] = '{32'h204, 32'h30f, 4'h0, 4'h5, 4'h1, 8'h0, 4'h1, 2'h0, 4'h3};
    rows[3] = '{32'h105, 32'h0, 4'h0, 4'h0, 4'h0, 8'h0, 4'h0, 2'h1, 4'h0};
    tick(10);
    aresetn <= 1'b1;
    tick(3);
    rdr(OFF_ORIGIN);
    chk("origin", 32'h1, rd);
    rdr(OFF_SWITCH);
    chk("switch", SWITCH_RST, rd);
    chk("battery", 1'b0, backup_domain_on_battery);
    chk("slow_osc", 1'b1, always_on_slow_osc_en);
    wr(8'h40, 32'h0);
    chk("bresp", RESP_SLVERR, rs);
    wr(OFF_BODLVL, 32'h2a);
    tick(3);
    chk("thr", 32'h2a, brownout_threshold);
    chk("ref", 1'b0, brownout_ref_main);
    wr(8'h20, 32'h5a5a_0001);
    foreach (rows[i]) begin
      r = rows[i];
      wr(OFF_IRQEN, 32'hff);
      wr(OFF_CLKCFG, r.clk);
      wr(OFF_CTRL, r.ctl);
      bus_clk_req <= r.br;
      gclk_req <= r.gr;
      wfi_exec <= 1'b1;
      @(posedge aclk);
      wfi_exec <= 1'b0;
      tick(3);
      chk("cpu", r.exp_cbrm[3], cpu_clk_en);
      chk("bus", r.exp_cbrm[2], bus_clk_en);
      chk("gclk", r.eg, generic_peripheral_clock_en);
      chk("lpreg", r.exp_cbrm[1], low_power_regulator_sel);
      chk("main", r.exp_cbrm[0], main_power_en);
      if (r.wk != 2'h0) begin
        irq_line <= 8'hff;
        async_irq <= 4'hf;
        tick(8);
        chk("no_wake", 1'b0, cpu_clk_en);
      end
      irq_line <= r.irq;
      async_irq <= r.air;
      ext_wake_pin <= r.wk;
      wake_wait();
      chk("awake", 1'b1, cpu_clk_en);
      irq_line <= 8'h00;
      async_irq <= 4'h0;
      ext_wake_pin <= 2'h0;
      bus_clk_req <= 4'h0;
      gclk_req <= 4'h0;
      tick(4);
    end
    chk("restart", 1'b1, seen);
    chk("io_hold", 1'b1, io_hold);
    rdr(OFF_ORIGIN);
    chk("origin", 32'h14, rd);
    rdr(OFF_CTRL);
    chk("ctrl", 32'h300, rd);
    rdr(8'h20);
    chk("gp", 32'h5a5a_0001, rd);
    chk("rresp", RESP_OKAY, rs);
    wr(OFF_SWITCH, 32'h2);
    tick(4);
    chk("battery", 1'b1, backup_domain_on_battery);
    aresetn <= 1'b0;
    tick(10);
    aresetn <= 1'b1;
    tick(3);
    chk("battery", 1'b0, backup_domain_on_battery);
    wr(OFF_SWITCH, 32'h5);
    drop <= 1'b1;
    tick(8);
    chk("main", 1'b0, main_power_en);
    chk("battery", 1'b1, backup_domain_on_battery);
    chk("ref", 1'b1, brownout_ref_main);
    drop <= 1'b0;
    wake_wait();
    chk("awake", 1'b1, cpu_clk_en);
    chk("battery", 1'b0, backup_domain_on_battery);
    rdr(OFF_ORIGIN);
    chk("origin", 32'h44, rd);
    wr(OFF_SWITCH, 32'h3f);
    drop <= 1'b1;
    supply_brownout_trip <= 1'b1;
    tick(8);
    chk("battery", 1'b1, backup_domain_on_battery);
    chk("main", 1'b0, main_power_en);
    drop <= 1'b0;
    supply_brownout_trip <= 1'b0;
    wake_wait();
    chk("battery", 1'b0, backup_domain_on_battery);
    stop_test();
  end
endmodule // low_power_mode_controller_tb
